//--- hw/adcc_top.sv
/*
  Converter control block: control/result registers on Avalon-MM, conversion
  sequencer driving a successive-approximation core, power mode handling and
  interrupt/wake logic. Assumes the analog comparator output is synchronous
  to REF_CLK and that WAIT/STOP levels come from the core's power controller.
*/
`timescale 1ns/10ps
module adcc_top
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  // Avalon-MM slave
  input wire logic [ADCC_AW-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Power modes
  input wire logic WAIT_MODE,
  input wire logic STOP_MODE,
  output logic WAKE_FROM_WAIT,
  output logic MAIN_OSC_DISABLE,
  // Analog core
  input wire logic CMP_ABOVE,
  output logic [7:0] SAR_CODE,
  output logic CONVERTER_POWER_ON,
  output logic SAMPLE_ACTIVE,
  // Interrupts
  output logic CONV_IRQ,
  output logic EVT_IRQ
);
  ////////////////////////////////////////////////////////////////////////////
  logic conversion_irq_enable_q;
  logic eoc_q;
  logic converter_power_on_q;
  logic main_osc_disable_q;
  logic [7:0] result_q;
  logic [7:0] sar_q;
  logic [2:0] bit_idx_q;
  logic [15:0] tick_q;
  adcc_state_t state_q;
  logic [ADCC_NEVT-1:0] evt_status_q;
  logic [ADCC_NEVT-1:0] evt_mask_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic done_pulse;
  logic abort_pulse;
  logic wr_ctrl;
  logic start_cmd;
  logic conv_allowed;
  logic acc;

  ////////////////////////////////////////////////////////////////////////////
  // Bus access decode: one wait cycle, then acknowledge
  assign acc = (AVS_READ || AVS_WRITE) && !ack_q;
  assign wr_ctrl = CLK_EN && AVS_WRITE && !ack_q && AVS_BYTEENABLE[0]
                   && (AVS_ADDRESS == ADCC_ADDR_CTRL);
  assign start_cmd = wr_ctrl && AVS_WRITEDATA[ADCC_BIT_START];
  assign conv_allowed = converter_power_on_q && !STOP_MODE;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
    end else if (CLK_EN) begin
      ack_q <= acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      conversion_irq_enable_q <= ADCC_CTRL_RST[ADCC_BIT_IRQ_EN];
      converter_power_on_q <= ADCC_CTRL_RST[ADCC_BIT_POWER];
      main_osc_disable_q <= ADCC_CTRL_RST[ADCC_BIT_OSC_OFF];
    end else if (wr_ctrl) begin
      conversion_irq_enable_q <= AVS_WRITEDATA[ADCC_BIT_IRQ_EN];
      converter_power_on_q <= AVS_WRITEDATA[ADCC_BIT_POWER];
      main_osc_disable_q <= AVS_WRITEDATA[ADCC_BIT_OSC_OFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ADCC_IDLE;
      sar_q <= 8'h00;
      bit_idx_q <= 3'd7;
      tick_q <= 16'h0000;
    end else if (CLK_EN) begin
      if (!conv_allowed) begin
        state_q <= ADCC_IDLE;
      end else if (start_cmd) begin
        state_q <= ADCC_CONV;
        sar_q <= 8'h80;
        bit_idx_q <= 3'(ADCC_NBITS - 1);
        tick_q <= 16'h0000;
      end else begin
        case (state_q)
          ADCC_CONV: begin
            if (tick_q == 16'(ADCC_BIT_CYC - 1)) begin
              tick_q <= 16'h0000;
              if (!CMP_ABOVE) begin
                sar_q[bit_idx_q] <= 1'b0;
              end
              if (bit_idx_q == 3'd0) begin
                state_q <= ADCC_DONE_ST;
              end else begin
                sar_q[bit_idx_q - 3'd1] <= 1'b1;
                bit_idx_q <= bit_idx_q - 3'd1;
              end
            end else begin
              tick_q <= tick_q + 16'h0001;
            end
          end
          ADCC_DONE_ST: begin
            state_q <= ADCC_IDLE;
          end
          default: begin
            state_q <= ADCC_IDLE;
          end
        endcase
      end
    end
  end

  assign done_pulse = CLK_EN && conv_allowed && !start_cmd && (state_q == ADCC_DONE_ST);
  assign abort_pulse = CLK_EN && (state_q == ADCC_CONV)
                       && (!conv_allowed || start_cmd);

  ////////////////////////////////////////////////////////////////////////////
  // Completion flag and result
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      eoc_q <= ADCC_CTRL_RST[ADCC_BIT_EOC];
    end else if (CLK_EN) begin
      if (start_cmd && conv_allowed) begin
        eoc_q <= 1'b0;
      end else if (done_pulse) begin
        eoc_q <= 1'b1;
      end else if (abort_pulse) begin
        eoc_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      result_q <= ADCC_RESULT_RST;
    end else if (done_pulse) begin
      result_q <= sar_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status and mask
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      evt_status_q <= '0;
      evt_mask_q <= '0;
    end else if (CLK_EN) begin
      for (int i = 0; i < ADCC_NEVT; i++) begin
        if ((i == ADCC_ST_DONE && done_pulse) || (i == ADCC_ST_ABORT && abort_pulse)) begin
          evt_status_q[i] <= 1'b1;
        end else if (AVS_WRITE && !ack_q && AVS_BYTEENABLE[0]
                     && AVS_ADDRESS == ADCC_ADDR_STATUS && AVS_WRITEDATA[i]) begin
          evt_status_q[i] <= 1'b0;
        end
      end
      if (AVS_WRITE && !ack_q && AVS_BYTEENABLE[0] && AVS_ADDRESS == ADCC_ADDR_MASK) begin
        evt_mask_q <= AVS_WRITEDATA[ADCC_NEVT-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (CLK_EN) begin
      rdata_q <= 32'h0000_0000;
      if (AVS_READ && !ack_q) begin
        if (AVS_ADDRESS == ADCC_ADDR_CTRL) begin
          rdata_q[ADCC_BIT_IRQ_EN] <= conversion_irq_enable_q;
          rdata_q[ADCC_BIT_EOC] <= eoc_q;
          rdata_q[ADCC_BIT_POWER] <= converter_power_on_q;
          rdata_q[ADCC_BIT_OSC_OFF] <= main_osc_disable_q;
        end else if (AVS_ADDRESS == ADCC_ADDR_RESULT) begin
          rdata_q[7:0] <= result_q;
        end else if (AVS_ADDRESS == ADCC_ADDR_STATUS) begin
          rdata_q[ADCC_NEVT-1:0] <= evt_status_q;
        end else if (AVS_ADDRESS == ADCC_ADDR_MASK) begin
          rdata_q[ADCC_NEVT-1:0] <= evt_mask_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CONV_IRQ <= 1'b0;
      WAKE_FROM_WAIT <= 1'b0;
      EVT_IRQ <= 1'b0;
      SAR_CODE <= 8'h00;
      SAMPLE_ACTIVE <= 1'b0;
      CONVERTER_POWER_ON <= 1'b0;
      MAIN_OSC_DISABLE <= 1'b0;
    end else if (CLK_EN) begin
      CONV_IRQ <= conversion_irq_enable_q && eoc_q && !(start_cmd && conv_allowed);
      WAKE_FROM_WAIT <= conversion_irq_enable_q && eoc_q && WAIT_MODE && !STOP_MODE
                        && !(start_cmd && conv_allowed);
      EVT_IRQ <= |(evt_status_q & evt_mask_q);
      SAR_CODE <= sar_q;
      SAMPLE_ACTIVE <= (state_q == ADCC_CONV) && conv_allowed;
      CONVERTER_POWER_ON <= conv_allowed;
      MAIN_OSC_DISABLE <= main_osc_disable_q;
    end
  end

  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = !ack_q;
endmodule : adcc_top

//--- hw/adcc_pkg.sv
/*
  Package for the converter control block: register offsets, bit positions,
  reset values, timing constants, state enum and bus carrier structs.
  Assumes a 50 MHz REF_CLK and a 32-bit Avalon-MM register bus.
*/
package adcc_pkg;
  // Register indices (printed offsets are not word multiples)
  localparam logic [9:0] ADCC_IDX_CTRL = 10'h0d0;
  localparam logic [9:0] ADCC_IDX_RESULT = 10'h0d1;
  localparam logic [9:0] ADCC_IDX_STATUS = 10'h0d2;
  localparam logic [9:0] ADCC_IDX_MASK = 10'h0d3;
  localparam int ADCC_AW = 12;
  localparam logic [11:0] ADCC_ADDR_CTRL = {ADCC_IDX_CTRL, 2'b00};
  localparam logic [11:0] ADCC_ADDR_RESULT = {ADCC_IDX_RESULT, 2'b00};
  localparam logic [11:0] ADCC_ADDR_STATUS = {ADCC_IDX_STATUS, 2'b00};
  localparam logic [11:0] ADCC_ADDR_MASK = {ADCC_IDX_MASK, 2'b00};
  // Control bit positions
  localparam int ADCC_BIT_IRQ_EN = 7;
  localparam int ADCC_BIT_EOC = 6;
  localparam int ADCC_BIT_START = 5;
  localparam int ADCC_BIT_POWER = 4;
  localparam int ADCC_BIT_OSC_OFF = 2;
  // Status / mask bit positions
  localparam int ADCC_ST_DONE = 0;
  localparam int ADCC_ST_ABORT = 1;
  localparam int ADCC_NEVT = 2;
  // Reset values
  localparam logic [7:0] ADCC_CTRL_RST = 8'h40;
  localparam logic [7:0] ADCC_RESULT_RST = 8'h00;
  // Timing: conversion time in ns and its cycle count at REF_CLK
  localparam int ADCC_CLK_HZ = 50000000;
  localparam int ADCC_CONV_NS = 70000;
  localparam int ADCC_CONV_CYC = (ADCC_CONV_NS / 1000) * (ADCC_CLK_HZ / 1000000);
  localparam int ADCC_BIT_CYC = ADCC_CONV_CYC / 8;
  localparam int ADCC_NBITS = 8;
  typedef enum logic [1:0] {ADCC_IDLE, ADCC_CONV, ADCC_DONE_ST} adcc_state_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [ADCC_AW-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } adcc_req_t;
  typedef struct packed {
    logic waitrequest;
    logic readdatavalid;
    logic [31:0] readdata;
  } adcc_rsp_t;
endpackage : adcc_pkg

//--- verification/adcc_props.sv
/* Port checker for adcc_top, bound at the foot of this file.
   Assumes one clock domain and whole Avalon requests. */
`timescale 1ns/10ps
module adcc_props
  import adcc_pkg::*;
(
  // Clock, reset and bus
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic [ADCC_AW-1:0] AVS_ADDRESS,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic AVS_WAITREQUEST,
  // Power and converter
  input wire logic WAIT_MODE,
  input wire logic STOP_MODE,
  input wire logic WAKE_FROM_WAIT,
  input wire logic MAIN_OSC_DISABLE,
  input wire logic CONVERTER_POWER_ON,
  input wire logic SAMPLE_ACTIVE,
  input wire logic CONV_IRQ,
  input wire logic EVT_IRQ
);
  logic wr_ctl;
  logic go;
  assign wr_ctl = AVS_WRITE && AVS_WAITREQUEST && CLK_EN && AVS_BYTEENABLE[0] &&
    AVS_ADDRESS == ADCC_ADDR_CTRL;
  assign go = wr_ctl && AVS_WRITEDATA[ADCC_BIT_START] && CONVERTER_POWER_ON && !STOP_MODE;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  chk_start_runs: assert property (go |=> ##[0:1] SAMPLE_ACTIVE)
    else $error("start did not launch a conversion");
  chk_start_irq: assert property (go |-> ##2 !CONV_IRQ)
    else $error("start left the request up");
  chk_stop_idle: assert property (STOP_MODE ##1 STOP_MODE |=> !SAMPLE_ACTIVE)
    else $error("conversion active while stopped");
  chk_stop_power: assert property (STOP_MODE |=> !CONVERTER_POWER_ON)
    else $error("converter powered while stopped");
  chk_stop_wake: assert property (STOP_MODE |=> !WAKE_FROM_WAIT)
    else $error("wake raised while stopped");
  chk_wake_cause: assert property (WAKE_FROM_WAIT |-> CONV_IRQ && $past(WAIT_MODE))
    else $error("wake without request in wait");
  chk_power_bit: assert property (wr_ctl ##1 !STOP_MODE |=>
    CONVERTER_POWER_ON == $past(AVS_WRITEDATA[ADCC_BIT_POWER], 2))
    else $error("power output does not follow bit 4");
  chk_osc_bit: assert property (wr_ctl |-> ##2
    MAIN_OSC_DISABLE == $past(AVS_WRITEDATA[ADCC_BIT_OSC_OFF], 2))
    else $error("oscillator output does not follow bit 2");
  chk_ack_once: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for two cycles");
  cov_start: cover property (go);
  cov_wake: cover property ($rose(WAKE_FROM_WAIT));
  cov_evt: cover property ($rose(EVT_IRQ));
  cov_abort: cover property (STOP_MODE && SAMPLE_ACTIVE);
endmodule : adcc_props

bind adcc_top adcc_props u_props (.*);

//--- verification/tb_top.sv
/* Self-checking bench for adcc_top with random and corner input codes.
   Assumes the checker is bound to the design. */
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("BAD %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top;
  import adcc_pkg::*;
  logic REF_CLK = 1'h0, RST_N = 1'h0, CLK_EN = 1'h1, AVS_READ = 1'h0, AVS_WRITE = 1'h0;
  logic WAIT_MODE = 1'h0, STOP_MODE = 1'h0, CMP_ABOVE = 1'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic [11:0] AVS_ADDRESS = 12'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
  logic AVS_WAITREQUEST, WAKE_FROM_WAIT, MAIN_OSC_DISABLE, CONVERTER_POWER_ON;
  logic SAMPLE_ACTIVE, CONV_IRQ, EVT_IRQ;
  logic [7:0] SAR_CODE, vin = 8'h0;
  int err_count = 0, num_checks = 0, seed = 32'h0201eafc;
  adcc_top DUT (.*);
  always #10 REF_CLK = ~REF_CLK;
  // Analog input model
  always @(posedge REF_CLK) CMP_ABOVE <= (vin >= SAR_CODE);
  ////////////////////////////////////////
  // unused bits zero
  function automatic logic [31:0] ctl(input logic en, input logic dn, input logic pw);
    return {24'h0, en, dn, 1'h0, pw, 4'h0};
  endfunction : ctl
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= d;
    @(posedge REF_CLK);
    while (AVS_WAITREQUEST !== 1'h0 && n < 20) begin
      @(posedge REF_CLK);
      n++;
    end
    if (n == 20) begin
      err_count++;
      results();
    end
    q = AVS_READDATA;
    AVS_READ <= 1'h0;
    AVS_WRITE <= 1'h0;
    @(posedge REF_CLK);
  endtask : xfer
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    `CHK(q, e)
  endtask : rd
  task automatic conv(input logic [7:0] v);
    int n;
    n = 0;
    vin <= v;
    xfer(1'h1, ADCC_ADDR_CTRL, 32'h90);
    xfer(1'h1, ADCC_ADDR_CTRL, 32'hb0);
    while (SAMPLE_ACTIVE !== 1'h0 && n < 4000) begin
      @(posedge REF_CLK);
      n++;
    end
    if (n == 4000) begin
      err_count++;
      results();
    end
    repeat (3) @(posedge REF_CLK);
  endtask : conv
  initial begin
    #(40000 * 20);
    err_count++;
    results();
  end
  initial begin
    repeat (2) @(posedge REF_CLK);
    RST_N <= 1'h1;
    @(posedge REF_CLK);
    rd(ADCC_ADDR_CTRL, ctl(0, 1, 0));
    rd(12'h3fc, 32'h0);
    xfer(1'h1, ADCC_ADDR_CTRL, 32'h20);
    `CHK(SAMPLE_ACTIVE, 1'h0)
    xfer(1'h1, ADCC_ADDR_MASK, 32'h3);
    for (int i = 0; i < 4; i++) begin
      conv(i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($random(seed)));
      rd(ADCC_ADDR_RESULT, {24'h0, vin});
      rd(ADCC_ADDR_CTRL, ctl(1, 1, 1));
      `CHK(CONV_IRQ, 1'h1)
      `CHK(EVT_IRQ, 1'h1)
      xfer(1'h1, ADCC_ADDR_STATUS, 32'h1);
      `CHK(EVT_IRQ, 1'h0)
      $display("conversion %0d done", i);
    end
    xfer(1'h1, ADCC_ADDR_CTRL, 32'h10);
    `CHK(CONV_IRQ, 1'h0)
    xfer(1'h1, ADCC_ADDR_CTRL, 32'h90);
    rd(ADCC_ADDR_CTRL, ctl(1, 1, 1));
    // Restart mid-run while in wait
    vin <= 8'h5a;
    xfer(1'h1, ADCC_ADDR_CTRL, 32'hb0);
    `CHK(CONV_IRQ, 1'h0)
    WAIT_MODE <= 1'h1;
    repeat (1000) @(posedge REF_CLK);
    conv(8'ha5);
    `CHK(WAKE_FROM_WAIT, 1'h1)
    rd(ADCC_ADDR_RESULT, 32'ha5);
    STOP_MODE <= 1'h1;
    repeat (2) @(posedge REF_CLK);
    `CHK(WAKE_FROM_WAIT, 1'h0)
    `CHK(CONVERTER_POWER_ON, 1'h0)
    $display("wait and restart done");
    // Stop in mid-conversion
    STOP_MODE <= 1'h0;
    WAIT_MODE <= 1'h0;
    xfer(1'h1, ADCC_ADDR_STATUS, 32'h3);
    xfer(1'h1, ADCC_ADDR_CTRL, 32'hb0);
    repeat (500) @(posedge REF_CLK);
    STOP_MODE <= 1'h1;
    repeat (3) @(posedge REF_CLK);
    `CHK(SAMPLE_ACTIVE, 1'h0)
    STOP_MODE <= 1'h0;
    repeat (3600) @(posedge REF_CLK);
    rd(ADCC_ADDR_CTRL, ctl(1, 0, 1));
    rd(ADCC_ADDR_STATUS, 32'h2);
    xfer(1'h1, ADCC_ADDR_MASK, 32'h0);
    `CHK(EVT_IRQ, 1'h0)
    xfer(1'h1, ADCC_ADDR_STATUS, 32'h2);
    rd(ADCC_ADDR_STATUS, 32'h0);
    xfer(1'h1, ADCC_ADDR_CTRL, 32'h04);
    `CHK(MAIN_OSC_DISABLE, 1'h1)
    rd(ADCC_ADDR_CTRL, 32'h04);
    $display("stop and oscillator done");
    results();
  end
endmodule : tb_top
